//--- pkg/fpg_pkg.sv
package fpg_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam int FPG_ADDR_W = 8;
	localparam logic [7:0] FPG_OFS_PINCTL = 8'h00;
	localparam logic [7:0] FPG_OFS_PINSTAT = 8'h04;

	// ****************************************
	// field layout and reset values
	// ****************************************
	localparam int FPG_NPINS = 4;
	localparam int FPG_LVL_LSB = 0;
	localparam int FPG_DIR_LSB = 4;
	localparam logic [3:0] FPG_DIR_RST = 4'hF;
	localparam logic [3:0] FPG_LVL_RST = 4'h0;

	typedef struct packed {
		logic [FPG_ADDR_W-1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} fpg_req_s;

	typedef struct packed {
		logic [3:0] out;
		logic [3:0] oe;
	} fpg_pad_s;

endpackage

//--- hw/fpg_gpio.sv
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
// How it works
// - upper nibble holds per-pin direction, 1 output, 0 input; resets to 1111
// - input pins report their current level in the lower-nibble bit on read
// - writing a data bit of an input pin never drives that pin
// - output pins drive the last written data bit; data bits reset to 0000
module fpg_gpio (
	input wire logic CLK_I,
	input wire logic RESETN_I,
	input wire logic [fpg_pkg::FPG_ADDR_W-1:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [7:0] RDATA_O,
	input wire logic [3:0] PIN_I,
	output logic [3:0] PIN_O,
	output logic [3:0] PIN_OE_O
);
	import fpg_pkg::*;

	// ****************************************
	// bus decode
	// ****************************************
	fpg_req_s req;
	logic [3:0] dir_q;
	logic [3:0] lvl_q;
	logic [7:0] rdata_d;
	logic [3:0] rd_level;
	logic hit_ctl;
	logic hit_stat;
	fpg_pad_s pad_d;

	function automatic logic hit(input logic [FPG_ADDR_W-1:0] a, input logic [7:0] ofs);
		hit = (a == ofs[FPG_ADDR_W-1:0]);
	endfunction

	assign req = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};
	assign hit_ctl = hit(req.addr, FPG_OFS_PINCTL);
	assign hit_stat = hit(req.addr, FPG_OFS_PINSTAT);

	// ****************************************
	// per pin read level and drive
	// ****************************************
	genvar n;
	generate
		for (n = 0; n < FPG_NPINS; n++) begin : g_pin
			assign rd_level[n] = dir_q[n] ? lvl_q[n] : PIN_I[n];
			assign pad_d.oe[n] = dir_q[n];
			assign pad_d.out[n] = dir_q[n] & lvl_q[n];
		end
	endgenerate

	// status word: raw pin levels regardless of direction
	assign rdata_d = !req.rd ? 8'h00 :
		hit_ctl ? {dir_q, rd_level} :
		hit_stat ? {4'h0, PIN_I} : 8'h00;

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			dir_q <= FPG_DIR_RST;
			lvl_q <= FPG_LVL_RST;
		end else if (req.wr && hit_ctl) begin
			dir_q <= req.wdata[FPG_DIR_LSB +: FPG_NPINS];
			lvl_q <= req.wdata[FPG_LVL_LSB +: FPG_NPINS];
		end
	end

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			RDATA_O <= 8'h00;
			PIN_O <= FPG_LVL_RST;
			PIN_OE_O <= FPG_DIR_RST;
		end else begin
			RDATA_O <= rdata_d;
			PIN_O <= pad_d.out;
			PIN_OE_O <= pad_d.oe;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RESETN_I);

	dir_write_a: assert property (req.wr && hit_ctl |=> dir_q == $past(req.wdata[7:4]))
		else $error("direction nibble not updated");
	read_input_a: assert property (req.rd && hit_ctl && dir_q == 4'h0
		|=> RDATA_O[3:0] == $past(PIN_I))
		else $error("input level not returned");
	no_drive_a: assert property (##1 (dir_q == 4'h0) |=> PIN_OE_O == 4'h0)
		else $error("input pin driven");
	drive_val_a: assert property (req.wr && hit_ctl |=> ##1 PIN_O == ($past(req.wdata[7:4], 2)
		& $past(req.wdata[3:0], 2)))
		else $error("output level wrong");
	oe_follow_a: assert property (##1 PIN_OE_O == $past(dir_q))
		else $error("enable not following direction");
	pin_map_a: assert property (req.rd && hit_ctl && dir_q[0] && !dir_q[1]
		|=> RDATA_O[0] == $past(lvl_q[0]) && RDATA_O[1] == $past(PIN_I[1]))
		else $error("pin bit mapping wrong");
	idle_read_a: assert property (!req.rd |=> RDATA_O == 8'h00)
		else $error("read data outside read cycle");
	unmapped_a: assert property (req.rd && !hit_ctl && !hit_stat |=> RDATA_O == 8'h00)
		else $error("unmapped read nonzero");

	c_out_c: cover property (req.wr && hit_ctl && req.wdata == 8'hF5);
	c_in_c: cover property (req.wr && hit_ctl && req.wdata[7:4] == 4'h0 ##1 req.rd && hit_ctl);
	c_mix_c: cover property (dir_q == 4'h5 && req.rd && hit_ctl);
endmodule

//--- verification/fpg_board.sv
`timescale 1ns/1ps
module fpg_board (
	input wire logic [3:0] oe_i,
	input wire logic [3:0] out_i,
	input wire logic [3:0] drv_i,
	output logic [3:0] lvl_o
);
	// chip drives enabled pins, board the rest
	assign lvl_o = (oe_i & out_i) | (~oe_i & drv_i);
endmodule

//--- verification/four_pin_gpio_control_tb.sv
`timescale 1ns/1ps
module four_pin_gpio_control_tb;
	import fpg_pkg::*;
	logic clk = 0, rst_n = 0, wr = 0, rd = 0;
	logic [7:0] addr = 8'h00, wd = 8'h00, rdata;
	logic [3:0] pin_i, pin_o, oe, drv = 4'h0;
	int fails = 0, checked = 0, cyc = 0;
	fpg_gpio dut (.CLK_I(clk), .RESETN_I(rst_n), .ADDR_I(addr), .WDATA_I(wd), .WR_I(wr),
		.RD_I(rd), .RDATA_O(rdata), .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE_O(oe));
	fpg_board brd (.oe_i(oe), .out_i(pin_o), .drv_i(drv), .lvl_o(pin_i));
	initial begin
		forever #20 clk = ~clk;
	end
	task chk(input string n, input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk("rdata", rdata, e);
	endtask
	task results;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 400) begin
			fails++;
			results();
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		chk("oe", {4'h0, oe}, 8'h0F);
		chk("pin", {4'h0, pin_o}, 8'h00);
		rd_chk(FPG_OFS_PINCTL, 8'hF0);
		wr_reg(FPG_OFS_PINCTL, 8'hA5);
		chk("oe", {4'h0, oe}, 8'h0A);
		chk("pin", {4'h0, pin_o}, 8'h00);
		rd_chk(FPG_OFS_PINCTL, 8'hA0);
		@(posedge clk) drv <= 4'h9;
		rd_chk(FPG_OFS_PINCTL, 8'hA1);
		wr_reg(FPG_OFS_PINCTL, 8'h36);
		chk("oe", {4'h0, oe}, 8'h03);
		chk("pin", {4'h0, pin_o}, 8'h02);
		rd_chk(FPG_OFS_PINCTL, 8'h3A);
		rd_chk(FPG_OFS_PINSTAT, 8'h0A);
		rd_chk(8'h08, 8'h00);
		wr_reg(FPG_OFS_PINSTAT, 8'hFF);
		rd_chk(FPG_OFS_PINCTL, 8'h3A);
		@(posedge clk);
		#1;
		chk("rdata idle", rdata, 8'h00);
		wr_reg(FPG_OFS_PINCTL, 8'h0F);
		chk("oe", {4'h0, oe}, 8'h00);
		chk("pin", {4'h0, pin_o}, 8'h00);
		rd_chk(FPG_OFS_PINCTL, 8'h09);
		wr_reg(FPG_OFS_PINCTL, 8'h5F);
		chk("oe", {4'h0, oe}, 8'h05);
		chk("pin", {4'h0, pin_o}, 8'h05);
		rd_chk(FPG_OFS_PINCTL, 8'h5D);
		results();
	end
endmodule
